// File: logic/hes_status_select.sv
// Status and reason code selection for command, setup and link-loss events
`timescale 1ns/100ps
`default_nettype none
module hes_status_select
  import hes_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Command from the host decoder
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire logic [15:0]      cmd_opcode,
  input  wire hes_cmd_type      cmd_kind,
  input  wire logic             cmd_cc,
  input  wire logic [7:0]       cmd_reason,
  input  wire logic [7:0]       cmd_key_count,
  input  wire logic [2:0]       cmd_link,
  // Controller resources and mode
  input  wire logic             err_in_status,
  input  wire logic             conn_full,
  input  wire logic             sco_full,
  input  wire logic             acl_exists,
  input  wire logic             mem_full,
  input  wire logic [7:0]       key_free,
  input  wire logic             restrict_on,
  input  wire logic [15:0]      allow_op_a,
  input  wire logic [15:0]      allow_op_b,
  // Baseband results
  input  wire logic             bb_valid,
  output logic                  bb_ready,
  input  wire hes_bb_type       bb_kind,
  input  wire logic [2:0]       bb_link,
  // Event to the host
  output logic                  evt_valid,
  input  wire logic             evt_ready,
  output logic [2:0]            evt_kind,
  output logic [7:0]            evt_status,
  output logic [15:0]           evt_opcode,
  output logic [2:0]            evt_handle,
  output logic [7:0]            evt_count,
  // Connection table occupancy
  output logic [HANDLES-1:0]    handle_used
);

  typedef enum logic [2:0] {
    S_IDLE, S_SCAN_RD, S_SCAN_CHK, S_DECIDE, S_WAIT_BB,
    S_WALK_RD, S_WALK_CHK, S_WALK_END
  } hes_fsm_type;

  typedef struct packed {
    hes_fsm_type         fsm;
    hes_evt_type         e0;
    hes_evt_type         e1;
    hes_cmd_type         pend_kind;
    logic [15:0]         pend_op;
    logic [2:0]          pend_link;
    logic                walk_ret;
    logic [2:0]          lost_link;
    logic [2:0]          idx;
    logic [3:0]          acl_cnt;
    logic [3:0]          sco_cnt;
    logic [HANDLES-1:0]  used;
  } hes_state_type;

  hes_state_type      st_r;
  hes_state_type      st_nxt;
  logic               mem_we;
  logic [2:0]         mem_waddr;
  logic [ENTRY_W-1:0] mem_wdata;
  logic [ENTRY_W-1:0] mem_rdata;

  // A full table gives 0; the decide step refuses that case beforehand for every kind but CMD_AUTH
  function automatic logic [2:0] first_free(input logic [HANDLES-1:0] u);
    logic [2:0] f;
    f = '0;
    for (int i = HANDLES - 1; i >= 0; i--) begin
      if (!u[i]) begin
        f = 3'(i);
      end
    end
    return f;
  endfunction : first_free

  function automatic logic [7:0] min8(input logic [7:0] a,
                                      input logic [7:0] b);
    return (a < b) ? a : b;
  endfunction : min8

  // Status event kind used when the command itself is answered at once
  function automatic logic [2:0] own_kind(input logic cc);
    return cc ? EV_CMD_COMPLETE : EV_CMD_STATUS;
  endfunction : own_kind

  // Open table entry that points at the given physical link
  function automatic logic on_link(input logic               used_bit,
                                   input logic [ENTRY_W-1:0] entry,
                                   input logic [LINK_W-1:0]  link);
    return used_bit && entry[LINK_W-1:0] == link;
  endfunction : on_link

  // One index serves scan and walk; it wraps after the last handle
  function automatic logic [2:0] next_idx(input logic [2:0] i);
    return i + 3'h1;
  endfunction : next_idx

  function automatic logic at_last(input logic [2:0] i);
    return i == LAST_HANDLE;
  endfunction : at_last

  hes_link_mem u_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_addr (st_r.idx),
    .rd_data (mem_rdata)
  );

  always_comb begin
    logic       empty;
    logic       allowed;
    logic       hit;
    logic [7:0] err;
    logic [2:0] hnd;
    st_nxt    = st_r;
    cmd_ready = 1'b0;
    bb_ready  = 1'b0;
    mem_we    = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    err       = ST_SUCCESS; // R20
    hnd       = first_free(st_r.used);
    hit       = 1'b0;
    empty     = !st_r.e0.v && !st_r.e1.v;
    allowed   = (cmd_kind == CMD_RESET) || // R16
                (cmd_opcode == allow_op_a) || (cmd_opcode == allow_op_b);

    // Hand the front event to the host; the second slot moves up
    if (st_r.e0.v && evt_ready) begin
      st_nxt.e0 = st_r.e1;
      st_nxt.e1 = '0;
    end

    unique case (st_r.fsm)
      S_IDLE: begin
        if (bb_valid && bb_kind == BB_SUP_EXPIRE) begin
          bb_ready         = 1'b1;
          st_nxt.lost_link = bb_link; // R7
          st_nxt.walk_ret  = 1'b0;
          st_nxt.idx       = '0;
          st_nxt.fsm       = S_WALK_RD;
        end else if (bb_valid) begin
          // A result with nothing pending is stale and is dropped
          bb_ready = 1'b1;
        end else if (cmd_valid && empty) begin
          cmd_ready        = 1'b1;
          st_nxt.pend_kind = cmd_kind;
          st_nxt.pend_op   = cmd_opcode;
          st_nxt.pend_link = cmd_link;
          if (restrict_on && !allowed) begin
            // Opcode is not decoded here, so unknown ones also land here
            st_nxt.e0 = mk_evt(own_kind(cmd_cc), ST_DISALLOWED, // R14 R15
                               cmd_opcode, '0, '0);
          end else begin
            unique case (cmd_kind)
              CMD_CREATE_CONN, CMD_ADD_SCO: begin
                st_nxt.idx     = '0;
                st_nxt.acl_cnt = '0;
                st_nxt.sco_cnt = '0;
                st_nxt.fsm     = S_SCAN_RD;
              end
              CMD_REMOTE_NAME, CMD_AUTH: begin
                st_nxt.fsm = S_DECIDE;
              end
              CMD_REJECT_CONN: begin
                st_nxt.e0 = mk_evt(EV_CMD_STATUS, ST_SUCCESS, // R11
                                   cmd_opcode, '0, '0);
                st_nxt.e1 = mk_evt(EV_CONN_COMPLETE, cmd_reason, // R17 R18
                                   cmd_opcode, '0, '0);
              end
              CMD_WRITE_KEYS: begin
                // Partial store is not an error; the count tells the host
                st_nxt.e0 = mk_evt(EV_CMD_COMPLETE, ST_SUCCESS, cmd_opcode,
                                   '0, min8(cmd_key_count, key_free)); // R6
              end
              CMD_STORE_PARAM: begin
                err       = mem_full ? ST_MEM_FULL : ST_SUCCESS; // R5
                st_nxt.e0 = mk_evt(EV_CMD_COMPLETE, err, cmd_opcode,
                                   '0, '0);
              end
              CMD_RESET: begin
                st_nxt.used = '0;
                st_nxt.e0   = mk_evt(EV_CMD_COMPLETE, ST_SUCCESS,
                                     cmd_opcode, '0, '0);
              end
              CMD_OTHER: begin
                st_nxt.e0 = mk_evt(own_kind(cmd_cc), ST_SUCCESS,
                                   cmd_opcode, '0, '0);
              end
              default: begin
                st_nxt.e0 = mk_evt(own_kind(cmd_cc), ST_UNKNOWN_CMD, // R19
                                   cmd_opcode, '0, '0);
              end
            endcase
          end
        end
      end

      // Count the ACL and SCO entries already open to the target link
      S_SCAN_RD: begin
        st_nxt.fsm = S_SCAN_CHK;
      end

      S_SCAN_CHK: begin
        if (on_link(st_r.used[st_r.idx], mem_rdata, st_r.pend_link)) begin
          if (mem_rdata[ENTRY_W-1]) begin
            st_nxt.sco_cnt = st_r.sco_cnt + 4'h1;
          end else begin
            st_nxt.acl_cnt = st_r.acl_cnt + 4'h1;
          end
        end
        st_nxt.idx = next_idx(st_r.idx);
        st_nxt.fsm = at_last(st_r.idx) ? S_DECIDE : S_SCAN_RD;
      end

      // Refusal priority: connection limit, then SCO limit, then ACL
      S_DECIDE: begin
        if (st_r.pend_kind != CMD_AUTH && (conn_full || &st_r.used)) begin
          err = ST_MAX_CONN; // R10
        end else if (st_r.pend_kind == CMD_ADD_SCO &&
                     (sco_full || st_r.sco_cnt >= SCO_LIMIT)) begin
          err = ST_MAX_SCO; // R12
        end else if (st_r.pend_kind == CMD_CREATE_CONN &&
                     (acl_exists || st_r.acl_cnt != 4'h0)) begin
          err = ST_ACL_EXISTS; // R13
        end
        if (err != ST_SUCCESS && err_in_status) begin
          st_nxt.e0  = mk_evt(EV_CMD_STATUS, err, st_r.pend_op, '0, '0);
          st_nxt.fsm = S_IDLE;
        end else begin
          st_nxt.e0 = mk_evt(EV_CMD_STATUS, ST_SUCCESS, // R11
                             st_r.pend_op, '0, '0);
          if (err != ST_SUCCESS) begin
            st_nxt.e1  = mk_evt(done_kind(st_r.pend_kind), err,
                                st_r.pend_op, '0, '0);
            st_nxt.fsm = S_IDLE;
          end else begin
            st_nxt.fsm = S_WAIT_BB;
          end
        end
      end

      S_WAIT_BB: begin
        if (bb_valid && bb_kind == BB_SUP_EXPIRE) begin
          bb_ready         = 1'b1;
          st_nxt.lost_link = bb_link; // R7
          st_nxt.walk_ret  = 1'b1;
          st_nxt.idx       = '0;
          st_nxt.fsm       = S_WALK_RD;
        end else if (cmd_valid && cmd_kind == CMD_RESET && empty) begin
          // Reset abandons the pending setup without a completion event
          cmd_ready   = 1'b1; // R16
          st_nxt.used = '0;
          st_nxt.e0   = mk_evt(EV_CMD_COMPLETE, ST_SUCCESS, cmd_opcode,
                               '0, '0);
          st_nxt.fsm  = S_IDLE;
        end else if (bb_valid && empty) begin
          bb_ready = 1'b1;
          unique case (bb_kind)
            BB_PAGE_TIMEOUT: err = ST_PAGE_TIMEOUT; // R1 R2
            BB_AUTH_BAD:     err = ST_AUTH_FAIL; // R3
            BB_PIN_MISSING:  err = ST_KEY_MISSING; // R4
            default:         err = ST_SUCCESS;
          endcase
          if (err == ST_SUCCESS && (st_r.pend_kind == CMD_CREATE_CONN ||
                                    st_r.pend_kind == CMD_ADD_SCO)) begin
            mem_we            = 1'b1;
            mem_waddr         = hnd;
            mem_wdata         = {st_r.pend_kind == CMD_ADD_SCO,
                                 st_r.pend_link};
            st_nxt.used[hnd]  = 1'b1;
          end
          st_nxt.e0  = mk_evt(done_kind(st_r.pend_kind), err,
                              st_r.pend_op, hnd, '0);
          st_nxt.fsm = S_IDLE;
        end
      end

      // Visit every handle; each one on the lost link is closed in turn
      S_WALK_RD: begin
        st_nxt.fsm = S_WALK_CHK;
      end

      S_WALK_CHK: begin
        hit = on_link(st_r.used[st_r.idx], mem_rdata, st_r.lost_link);
        if (!hit || empty) begin
          if (hit) begin
            st_nxt.e0 = mk_evt(EV_DISC_COMPLETE, ST_CONN_TIMEOUT, // R7 R8
                               '0, st_r.idx, '0);
            st_nxt.used[st_r.idx] = 1'b0;
          end
          st_nxt.idx = next_idx(st_r.idx);
          st_nxt.fsm = at_last(st_r.idx) ? S_WALK_END : S_WALK_RD;
        end
      end

      S_WALK_END: begin
        if (!st_r.walk_ret) begin
          st_nxt.fsm = S_IDLE;
        end else if (st_r.pend_link != st_r.lost_link) begin
          st_nxt.fsm = S_WAIT_BB;
        end else if (empty) begin
          // Setup was still open, so it ends with a completion, not a
          // disconnection
          st_nxt.e0  = mk_evt(done_kind(st_r.pend_kind), // R9
                              ST_CONN_TIMEOUT, st_r.pend_op, '0, '0);
          st_nxt.fsm = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign evt_valid   = st_r.e0.v;
  assign evt_kind    = st_r.e0.kind;
  assign evt_status  = st_r.e0.status;
  assign evt_opcode  = st_r.e0.opcode;
  assign evt_handle  = st_r.e0.handle;
  assign evt_count   = st_r.e0.count;
  assign handle_used = st_r.used;

endmodule : hes_status_select
`default_nettype wire

// File: logic/hes_pkg.sv
// Status codes, event encodings and shared helpers for the status selector
// Behaviour
// R1 - Create page timeout gives code 0x04
// R2 - Remote name page timeout gives 0x04
// R3 - Bad PIN or key gives 0x05
// R4 - Missing PIN codes give 0x06
// R5 - No room for parameters gives 0x07
// R6 - Key write stores what fits, no error
// R7 - Supervision expiry reports reason 0x08
// R8 - One disconnection event per handle on link
// R9 - Loss during setup: 0x08 in completion
// R10 - No further connections gives 0x09
// R11 - Error in later event: status shows success
// R12 - SCO limit to device gives 0x0a
// R13 - Second ACL to device gives 0x0b
// R14 - Restricted state rejects others with 0x0c
// R15 - Disallowed goes in complete or status
// R16 - Reset command is always accepted
// R17 - Host picks reject reason 0x0d-0x0f
// R18 - Host reject reason echoed in completion
// R19 - Unknown opcode gives code 0x01
// R20 - Codes are one byte, zero is success
`default_nettype none
package hes_pkg;

  // Status and reason codes
  localparam logic [7:0] ST_SUCCESS      = 8'h00;
  localparam logic [7:0] ST_UNKNOWN_CMD  = 8'h01;
  localparam logic [7:0] ST_PAGE_TIMEOUT = 8'h04;
  localparam logic [7:0] ST_AUTH_FAIL    = 8'h05;
  localparam logic [7:0] ST_KEY_MISSING  = 8'h06;
  localparam logic [7:0] ST_MEM_FULL     = 8'h07;
  localparam logic [7:0] ST_CONN_TIMEOUT = 8'h08;
  localparam logic [7:0] ST_MAX_CONN     = 8'h09;
  localparam logic [7:0] ST_MAX_SCO      = 8'h0a;
  localparam logic [7:0] ST_ACL_EXISTS   = 8'h0b;
  localparam logic [7:0] ST_DISALLOWED   = 8'h0c;

  // Event kinds presented to the host
  localparam logic [2:0] EV_CMD_COMPLETE  = 3'h0;
  localparam logic [2:0] EV_CMD_STATUS    = 3'h1;
  localparam logic [2:0] EV_CONN_COMPLETE = 3'h2;
  localparam logic [2:0] EV_NAME_COMPLETE = 3'h3;
  localparam logic [2:0] EV_AUTH_COMPLETE = 3'h4;
  localparam logic [2:0] EV_DISC_COMPLETE = 3'h5;

  // Connection table
  localparam int         HANDLES     = 8;
  localparam int         LINK_W      = 3;
  localparam int         ENTRY_W     = 4;
  localparam logic [2:0] LAST_HANDLE = 3'h7;
  localparam logic [3:0] SCO_LIMIT   = 4'h3;

  typedef enum logic [3:0] {
    CMD_CREATE_CONN, CMD_ADD_SCO, CMD_REMOTE_NAME, CMD_AUTH,
    CMD_REJECT_CONN, CMD_WRITE_KEYS, CMD_STORE_PARAM, CMD_RESET,
    CMD_OTHER, CMD_UNKNOWN
  } hes_cmd_type;

  typedef enum logic [2:0] {
    BB_SETUP_OK, BB_PAGE_TIMEOUT, BB_AUTH_BAD, BB_PIN_MISSING, BB_SUP_EXPIRE
  } hes_bb_type;

  typedef struct packed {
    logic        v;
    logic [2:0]  kind;
    logic [7:0]  status;
    logic [15:0] opcode;
    logic [2:0]  handle;
    logic [7:0]  count;
  } hes_evt_type;

  function automatic hes_evt_type mk_evt(input logic [2:0]  kind,
                                          input logic [7:0]  status,
                                          input logic [15:0] opcode,
                                          input logic [2:0]  handle,
                                          input logic [7:0]  count);
    hes_evt_type e;
    e.v      = 1'b1;
    e.kind   = kind;
    e.status = status;
    e.opcode = opcode;
    e.handle = handle;
    e.count  = count;
    return e;
  endfunction : mk_evt

  // Event that ends a setup-type command
  function automatic logic [2:0] done_kind(input hes_cmd_type k);
    if (k == CMD_REMOTE_NAME) begin
      return EV_NAME_COMPLETE;
    end
    if (k == CMD_AUTH) begin
      return EV_AUTH_COMPLETE;
    end
    return EV_CONN_COMPLETE;
  endfunction : done_kind

endpackage : hes_pkg
`default_nettype wire

// File: logic/hes_link_mem.sv
// Connection table memory: one {sco, link} entry per handle
`timescale 1ns/100ps
`default_nettype none
module hes_link_mem
  import hes_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Write port
  input  wire logic                wr_en,
  input  wire logic [2:0]          wr_addr,
  input  wire logic [ENTRY_W-1:0]  wr_data,
  // Read port, data one cycle after the address
  input  wire logic [2:0]          rd_addr,
  output logic      [ENTRY_W-1:0]  rd_data
);

  typedef struct packed {
    logic [HANDLES-1:0][ENTRY_W-1:0] mem;
    logic [ENTRY_W-1:0]              rd;
  } hes_mem_state_type;

  hes_mem_state_type st_r;
  hes_mem_state_type st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.rd = st_r.mem[rd_addr];
    if (wr_en) begin
      st_nxt.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd;

endmodule : hes_link_mem
`default_nettype wire

// File: tb/hes_status_select_sva.sv
// Port assertions for the status selector
`timescale 1ns/100ps
`default_nettype none
module hes_status_select_sva
  import hes_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Command side
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [15:0] cmd_opcode,
  input wire hes_cmd_type cmd_kind,
  input wire logic        cmd_cc,
  input wire logic [7:0]  cmd_key_count,
  // Resources and mode
  input wire logic        err_in_status,
  input wire logic        conn_full,
  input wire logic        mem_full,
  input wire logic [7:0]  key_free,
  input wire logic        restrict_on,
  input wire logic [15:0] allow_op_a,
  input wire logic [15:0] allow_op_b,
  // Baseband side
  input wire logic        bb_valid,
  input wire logic        bb_ready,
  input wire hes_bb_type  bb_kind,
  // Event side
  input wire logic        evt_valid,
  input wire logic        evt_ready,
  input wire logic [2:0]  evt_kind,
  input wire logic [7:0]  evt_status,
  input wire logic [15:0] evt_opcode,
  input wire logic [7:0]  evt_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic tk;
  logic bt;
  logic deny;
  assign tk = cmd_valid && cmd_ready;
  assign bt = bb_valid && bb_ready;
  // Reset kind always passes, whatever its opcode
  assign deny = restrict_on && cmd_kind != CMD_RESET &&
                cmd_opcode != allow_op_a && cmd_opcode != allow_op_b;

  a_evt_holds:
    assert property (evt_valid && !evt_ready |=> evt_valid &&
      $stable(evt_status) && $stable(evt_kind))
    else $error("event changed before acceptance");
  a_mem_full:
    assert property (tk && cmd_kind == CMD_STORE_PARAM && mem_full && !deny
      |=> evt_valid && evt_kind == EV_CMD_COMPLETE && evt_status == ST_MEM_FULL)
    else $error("memory full not reported");
  a_key_count:
    assert property (tk && cmd_kind == CMD_WRITE_KEYS && !deny
      |=> evt_status == ST_SUCCESS && evt_count == (($past(cmd_key_count) <
      $past(key_free)) ? $past(cmd_key_count) : $past(key_free)))
    else $error("stored key count wrong");
  a_unknown_op:
    assert property (tk && cmd_kind == CMD_UNKNOWN && !deny
      |=> evt_valid && evt_status == ST_UNKNOWN_CMD)
    else $error("unknown opcode not reported");
  a_cmd_denied:
    assert property (tk && deny |=> evt_valid && evt_status == ST_DISALLOWED &&
      evt_kind == ($past(cmd_cc) ? EV_CMD_COMPLETE : EV_CMD_STATUS))
    else $error("disallowed answer wrong");
  a_reset_ok:
    assert property (tk && cmd_kind == CMD_RESET
      |=> evt_valid && evt_status != ST_DISALLOWED)
    else $error("reset command refused");
  a_page_code:
    assert property (bt && bb_kind == BB_PAGE_TIMEOUT
      |=> !$rose(evt_valid) || evt_status == ST_PAGE_TIMEOUT)
    else $error("page timeout code wrong");
  a_pair_code:
    assert property (bt && (bb_kind == BB_AUTH_BAD || bb_kind == BB_PIN_MISSING)
      |=> !$rose(evt_valid) || evt_status == (($past(bb_kind) == BB_AUTH_BAD)
      ? ST_AUTH_FAIL : ST_KEY_MISSING))
    else $error("pairing failure code wrong");
  a_disc_reason:
    assert property (evt_valid && evt_kind == EV_DISC_COMPLETE
      |-> evt_status == ST_CONN_TIMEOUT && evt_opcode == 16'h0000)
    else $error("disconnection reason wrong");
  a_max_conn:
    assert property (tk && cmd_kind == CMD_CREATE_CONN && conn_full &&
      err_in_status && !deny |-> ##[1:20] (evt_valid &&
      evt_kind == EV_CMD_STATUS && evt_status == ST_MAX_CONN))
    else $error("max connections not reported");
  a_reject_first:
    assert property (tk && cmd_kind == CMD_REJECT_CONN && !deny
      |=> evt_kind == EV_CMD_STATUS && evt_status == ST_SUCCESS)
    else $error("reject status not success");

  c_disc: cover property (evt_valid && evt_kind == EV_DISC_COMPLETE);
  c_name: cover property (evt_valid && evt_kind == EV_NAME_COMPLETE);
  c_deny: cover property (tk && deny);
endmodule : hes_status_select_sva
`default_nettype wire

// File: tb/hes_host_model.sv
// Host side model that consumes events, optionally stalling
`timescale 1ns/100ps
`default_nettype none
module hes_host_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       slow,
  // Event from the controller
  input  wire logic       evt_valid,
  input  wire logic [2:0] evt_kind,
  input  wire logic [7:0] evt_status,
  input  wire logic [2:0] evt_handle,
  input  wire logic [7:0] evt_count,
  output logic            evt_ready
);
  logic       tgl_r;
  logic [2:0] got_kind;
  logic [2:0] got_handle;
  logic [7:0] got_status;
  logic [7:0] got_count;
  int         n_evt;
  // A slow host takes at most one event every other cycle
  assign evt_ready = !slow || tgl_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_r <= 1'b0;
      n_evt <= 0;
    end else begin
      tgl_r <= !tgl_r;
      if (evt_valid && evt_ready) begin
        got_kind   <= evt_kind;
        got_status <= evt_status;
        got_handle <= evt_handle;
        got_count  <= evt_count;
        n_evt      <= n_evt + 1;
      end
    end
  end
endmodule : hes_host_model
`default_nettype wire

// File: tb/hes_status_select_tb_top.sv
// Self-checking bench for the status selector
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module hes_status_select_tb_top
  import hes_pkg::*;
;
  logic               clk = 0, rst_b = 0, cmd_valid = 0, cmd_cc = 0;
  logic               err_in_status = 0, conn_full = 0, sco_full = 0;
  logic               acl_exists = 0, mem_full = 0, restrict_on = 0;
  logic               bb_valid = 0, slow = 0;
  logic [15:0]        cmd_opcode = 0, allow_op_a = 16'h0c01;
  logic [15:0]        allow_op_b = 16'h0c02;
  logic [7:0]         cmd_reason = 0, cmd_key_count = 0, key_free = 0;
  logic [2:0]         cmd_link = 0, bb_link = 0;
  hes_cmd_type        cmd_kind = CMD_OTHER;
  hes_bb_type         bb_kind = BB_SETUP_OK;
  logic               cmd_ready, bb_ready, evt_valid, evt_ready;
  logic [2:0]         evt_kind, evt_handle;
  logic [7:0]         evt_status, evt_count;
  logic [15:0]        evt_opcode;
  logic [HANDLES-1:0] handle_used;
  int                 n_errors = 0, total_checks = 0, seen = 0;

  always #20 clk = ~clk;
  hes_status_select dut (.*);
  hes_host_model host (.*);

  task automatic hs(ref logic v, ref logic r);
    int i = 0;
    v = 1;
    @(negedge clk);
    while (r !== 1'b1 && i < 100) begin
      @(negedge clk);
      i++;
    end
    if (r !== 1'b1) n_errors++;
    @(posedge clk);
    #1;
    v = 0;
  endtask : hs
  task automatic cmd(hes_cmd_type k, logic [15:0] op, logic cc);
    @(posedge clk);
    #1;
    cmd_kind = k;
    cmd_opcode = op;
    cmd_cc = cc;
    hs(cmd_valid, cmd_ready);
  endtask : cmd
  task automatic bb(hes_bb_type k, logic [2:0] l);
    @(posedge clk);
    #1;
    bb_kind = k;
    bb_link = l;
    hs(bb_valid, bb_ready);
  endtask : bb
  // Waits for the next accepted event and judges kind and status
  task automatic ev(logic [2:0] k, logic [7:0] s);
    int i = 0;
    while (host.n_evt == seen && i < 100) begin
      @(negedge clk);
      i++;
    end
    seen++;
    `CHK(host.n_evt, seen)
    `CHK(host.got_kind, k)
    `CHK(host.got_status, s)
    // Level inputs change only just after a rising edge
    @(posedge clk);
    #1;
  endtask : ev

  task automatic t_store;
    mem_full = 1;
    cmd(CMD_STORE_PARAM, 16'h0c05, 1);
    ev(EV_CMD_COMPLETE, ST_MEM_FULL);
    mem_full = 0;
    cmd_key_count = 8'h05;
    key_free = 8'h03;
    cmd(CMD_WRITE_KEYS, 16'h0c11, 1);
    ev(EV_CMD_COMPLETE, ST_SUCCESS);
    `CHK(host.got_count, 8'h03)
    cmd(CMD_UNKNOWN, 16'hfc77, 1);
    ev(EV_CMD_COMPLETE, ST_UNKNOWN_CMD);
  endtask : t_store
  task automatic t_restrict;
    restrict_on = 1;
    cmd(CMD_OTHER, 16'h1234, 1);
    ev(EV_CMD_COMPLETE, ST_DISALLOWED);
    cmd(CMD_UNKNOWN, 16'h4321, 0);
    ev(EV_CMD_STATUS, ST_DISALLOWED);
    cmd(CMD_OTHER, 16'h0c02, 0);
    ev(EV_CMD_STATUS, ST_SUCCESS);
    cmd(CMD_RESET, 16'h0c03, 1);
    ev(EV_CMD_COMPLETE, ST_SUCCESS);
    restrict_on = 0;
  endtask : t_restrict
  task automatic t_fail;
    hes_cmd_type k[4] = '{CMD_CREATE_CONN, CMD_REMOTE_NAME, CMD_AUTH, CMD_AUTH};
    hes_bb_type b[4] = '{BB_PAGE_TIMEOUT, BB_PAGE_TIMEOUT, BB_AUTH_BAD,
                         BB_PIN_MISSING};
    logic [2:0] e[4] = '{EV_CONN_COMPLETE, EV_NAME_COMPLETE, EV_AUTH_COMPLETE,
                         EV_AUTH_COMPLETE};
    logic [7:0] s[4] = '{ST_PAGE_TIMEOUT, ST_PAGE_TIMEOUT, ST_AUTH_FAIL,
                         ST_KEY_MISSING};
    cmd_link = 3'h1;
    for (int i = 0; i < 4; i++) begin
      cmd(k[i], 16'h0405, 0);
      ev(EV_CMD_STATUS, ST_SUCCESS);
      bb(b[i], 3'h1);
      ev(e[i], s[i]);
    end
  endtask : t_fail
  task automatic t_reject;
    for (logic [7:0] r = 8'h0d; r <= 8'h0f; r++) begin
      cmd_reason = r;
      cmd(CMD_REJECT_CONN, 16'h040a, 0);
      ev(EV_CMD_STATUS, ST_SUCCESS);
      ev(EV_CONN_COMPLETE, r);
    end
  endtask : t_reject
  task automatic t_loss;
    slow = 1;
    cmd_link = 3'h2;
    cmd(CMD_CREATE_CONN, 16'h0405, 0);
    ev(EV_CMD_STATUS, ST_SUCCESS);
    bb(BB_SETUP_OK, 3'h2);
    ev(EV_CONN_COMPLETE, ST_SUCCESS);
    cmd(CMD_ADD_SCO, 16'h0407, 0);
    ev(EV_CMD_STATUS, ST_SUCCESS);
    bb(BB_SETUP_OK, 3'h2);
    ev(EV_CONN_COMPLETE, ST_SUCCESS);
    `CHK(handle_used, 8'h03)
    cmd(CMD_CREATE_CONN, 16'h0405, 0);
    ev(EV_CMD_STATUS, ST_SUCCESS);
    ev(EV_CONN_COMPLETE, ST_ACL_EXISTS);
    bb(BB_SUP_EXPIRE, 3'h2);
    for (int h = 0; h < 2; h++) begin
      ev(EV_DISC_COMPLETE, ST_CONN_TIMEOUT);
      `CHK(host.got_handle, 3'(h))
    end
    // The handle walk takes 16 cycles; nothing further may follow
    repeat (40) @(posedge clk);
    #1;
    `CHK(host.n_evt, seen)
    `CHK(handle_used, 8'h00)
    cmd_link = 3'h3;
    cmd(CMD_CREATE_CONN, 16'h0405, 0);
    ev(EV_CMD_STATUS, ST_SUCCESS);
    bb(BB_SUP_EXPIRE, 3'h3);
    ev(EV_CONN_COMPLETE, ST_CONN_TIMEOUT);
    slow = 0;
  endtask : t_loss
  task automatic t_limits;
    err_in_status = 1;
    conn_full = 1;
    cmd(CMD_CREATE_CONN, 16'h0405, 0);
    ev(EV_CMD_STATUS, ST_MAX_CONN);
    err_in_status = 0;
    cmd(CMD_REMOTE_NAME, 16'h0419, 0);
    ev(EV_CMD_STATUS, ST_SUCCESS);
    ev(EV_NAME_COMPLETE, ST_MAX_CONN);
    conn_full = 0;
    sco_full = 1;
    cmd(CMD_ADD_SCO, 16'h0407, 0);
    ev(EV_CMD_STATUS, ST_SUCCESS);
    ev(EV_CONN_COMPLETE, ST_MAX_SCO);
    sco_full = 0;
    acl_exists = 1;
    err_in_status = 1;
    cmd(CMD_CREATE_CONN, 16'h0405, 0);
    ev(EV_CMD_STATUS, ST_ACL_EXISTS);
  endtask : t_limits

  task automatic print_verdict;
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_b = 1;
    t_store();
    t_restrict();
    t_fail();
    t_reject();
    t_loss();
    t_limits();
    print_verdict();
  end
  // The tests need well under a thousand cycles
  initial begin
    #(40 * 5000);
    n_errors++;
    print_verdict();
  end
endmodule : hes_status_select_tb_top
bind hes_status_select hes_status_select_sva u_sva (.*);
`default_nettype wire
